// *** shared/cocfg_pkg.sv ***
// Package of code option encodings and decoded constants for the option decoder.
`default_nettype none
package cocfg_pkg;
  // High clock source option.
  localparam logic [1:0] HCLK_INT_RC = 2'h0;
  localparam logic [1:0] HCLK_EXT_RC = 2'h1;
  localparam logic [1:0] HCLK_XTAL_FAST = 2'h2;
  localparam logic [1:0] HCLK_XTAL_STD = 2'h3;
  // Watchdog policy option.
  localparam logic [1:0] WDOG_ALWAYS_ON = 2'h0;
  localparam logic [1:0] WDOG_ENABLE = 2'h1;
  localparam logic [1:0] WDOG_DISABLE = 2'h2;
  // Instruction clock divider option.
  localparam logic [2:0] FCPU_DIV1 = 3'h0;
  localparam logic [2:0] FCPU_DIV2 = 3'h1;
  localparam logic [2:0] FCPU_DIV4 = 3'h2;
  localparam logic [2:0] FCPU_DIV8 = 3'h3;
  localparam logic [2:0] FCPU_DIV16 = 3'h4;
  // Low voltage option.
  localparam logic [1:0] LV_LOW = 2'h0;
  localparam logic [1:0] LV_MID = 2'h1;
  localparam logic [1:0] LV_HIGH = 2'h2;
  // Divider ratio in oscillator clocks and the fixed slow mode ratio.
  localparam logic [4:0] SLOW_DIV = 5'h04;
  localparam logic [4:0] MIN_FILTER_DIV = 5'h04;
  // Program flag register bit positions of the indicator bits.
  localparam logic [7:0] PROGRAM_FLAG_ADDR = 8'h86;
  localparam int SUPPLY_LOW_FLAG_HIGH_BIT = 5;
  localparam int SUPPLY_LOW_FLAG_MID_BIT = 4;
  // Brownout reset thresholds in millivolts.
  localparam logic [11:0] BROWNOUT_2V0_MV = 12'h07D0;
  localparam logic [11:0] BROWNOUT_2V4_MV = 12'h0960;
  // Internal RC frequency in MHz and program ROM size.
  localparam logic [4:0] INT_RC_MHZ = 5'h10;
  localparam int ROM_AW = 11;
  localparam logic [10:0] ROM_LAST_ADDR = 11'h7FF;
endpackage : cocfg_pkg
`default_nettype wire

// *** rtl/cocfg_decoder.sv ***
// Code option decoder: samples option bits at reset and drives static configuration.
// Overview of operation
// - Last ROM word reserved, excluded from checksums.
// - Internal RC: 16MHz, both oscillator pins port I/O.
// - External RC: output oscillator pin becomes port.
// - Crystal options drive both oscillator pins.
// - Always-on watchdog runs in every mode.
// - Enable halts in sleep; disable stops watchdog.
// - Instruction cycle is 1 to 16 oscillator clocks.
// - Filter on limits divider to 4..16.
// - Filter off allows dividers 1..16.
// - Reset pin or input-only port bit, no pull-up.
// - Security option enables ROM code protection.
// - Low/mid reset below 2.0V; mid enables 2.4V flag.
// - High resets below 2.4V, enables 3.6V flag.
// - Slow mode always uses low clock divided by four.
// - Indicator flags at program flag bits 5, 4.
`timescale 1ns/1ps
`default_nettype none
module cocfg_decoder (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Raw option bits from the option fuses.
  input wire logic [1:0] opt_high_clk_i,
  input wire logic [1:0] opt_watchdog_i,
  input wire logic [2:0] opt_fcpu_i,
  input wire logic opt_reset_pin_i,
  input wire logic opt_security_i,
  input wire logic opt_noise_filter_i,
  input wire logic [1:0] opt_low_volt_i,
  // Run state from the power controller.
  input wire logic slow_mode_i,
  input wire logic sleep_mode_i,
  // Brownout comparator results.
  input wire logic supply_below_2v0_i,
  input wire logic supply_below_2v4_i,
  input wire logic supply_below_3v6_i,
  // Clock unit configuration.
  output logic internal_rc_fast_osc_o,
  output logic osc_input_pin_is_port_o,
  output logic osc_output_pin_is_port_o,
  output logic crystal_drive_o,
  output logic crystal_fast_o,
  output logic [4:0] fcpu_div_o,
  output logic option_error_o,
  // Watchdog configuration.
  output logic watchdog_run_o,
  // Reset pin and security.
  output logic ext_reset_en_o,
  output logic port1_bit5_input_o,
  output logic port1_bit5_pullup_allow_o,
  output logic rom_protect_o,
  output logic [cocfg_pkg::ROM_AW-1:0] checksum_last_addr_o,
  // Low voltage unit.
  output logic brownout_reset_o,
  output logic [7:0] program_flag_register_o
);
  import cocfg_pkg::*;

  logic [1:0] hclk_q, hclk_d, wdog_q, wdog_d, lv_q, lv_d;
  logic [2:0] fcpu_q, fcpu_d;
  logic rstpin_q, rstpin_d, sec_q, sec_d, nf_q, nf_d;
  logic [4:0] div_d;

  // Decodes the divider code into a count of oscillator clocks.
  function automatic logic [4:0] fcpu_ratio(input logic [2:0] code);
    case (code)
      FCPU_DIV1: fcpu_ratio = 5'h01;
      FCPU_DIV2: fcpu_ratio = 5'h02;
      FCPU_DIV4: fcpu_ratio = 5'h04;
      FCPU_DIV8: fcpu_ratio = 5'h08;
      default: fcpu_ratio = 5'h10;
    endcase
  endfunction : fcpu_ratio

  // Options are latched while reset is held, so a fuse read that settles
  // late in reset is still caught; after release they never change.
  always_comb begin
    hclk_d = hclk_q;
    wdog_d = wdog_q;
    lv_d = lv_q;
    fcpu_d = fcpu_q;
    rstpin_d = rstpin_q;
    sec_d = sec_q;
    nf_d = nf_q;
    if (sys_rst_i) begin
      hclk_d = opt_high_clk_i;
      wdog_d = opt_watchdog_i;
      lv_d = opt_low_volt_i;
      fcpu_d = opt_fcpu_i;
      rstpin_d = opt_reset_pin_i;
      sec_d = opt_security_i;
      nf_d = opt_noise_filter_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    hclk_q <= hclk_d;
    wdog_q <= wdog_d;
    lv_q <= lv_d;
    fcpu_q <= fcpu_d;
    rstpin_q <= rstpin_d;
    sec_q <= sec_d;
    nf_q <= nf_d;
  end

  // Clock source and oscillator pin use.
  always_comb begin
    internal_rc_fast_osc_o = (hclk_q == HCLK_INT_RC);
    osc_input_pin_is_port_o = (hclk_q == HCLK_INT_RC);
    osc_output_pin_is_port_o = (hclk_q == HCLK_INT_RC) || (hclk_q == HCLK_EXT_RC);
    crystal_drive_o = (hclk_q == HCLK_XTAL_FAST) || (hclk_q == HCLK_XTAL_STD);
    crystal_fast_o = (hclk_q == HCLK_XTAL_FAST);
  end

  // A filter left on with a short divider is clamped to divide-by-4
  // instead of running out of range; the error flag tells the fuse was bad.
  always_comb begin
    div_d = fcpu_ratio(fcpu_q);
    option_error_o = 1'b0;
    if (nf_q && (div_d < MIN_FILTER_DIV)) begin
      div_d = MIN_FILTER_DIV;
      option_error_o = 1'b1;
    end
    if (slow_mode_i) begin
      div_d = SLOW_DIV;
    end
    fcpu_div_o = div_d;
  end

  // Watchdog run policy.
  always_comb begin
    case (wdog_q)
      WDOG_ALWAYS_ON: watchdog_run_o = 1'b1;
      WDOG_ENABLE: watchdog_run_o = !sleep_mode_i;
      default: watchdog_run_o = 1'b0;
    endcase
  end

  // Reset pin, security and checksum boundary.
  always_comb begin
    ext_reset_en_o = rstpin_q;
    port1_bit5_input_o = !rstpin_q;
    port1_bit5_pullup_allow_o = 1'b0;
    rom_protect_o = sec_q;
    checksum_last_addr_o = ROM_LAST_ADDR - 11'h001;
  end

  // Brownout reset and indicator flags; other flag bits belong to the core.
  always_comb begin
    program_flag_register_o = 8'h00;
    brownout_reset_o = 1'b0;
    case (lv_q)
      LV_HIGH: begin
        brownout_reset_o = supply_below_2v4_i;
        program_flag_register_o[SUPPLY_LOW_FLAG_HIGH_BIT] = supply_below_3v6_i;
      end
      LV_MID: begin
        brownout_reset_o = supply_below_2v0_i;
        program_flag_register_o[SUPPLY_LOW_FLAG_MID_BIT] = supply_below_2v4_i;
      end
      default: brownout_reset_o = supply_below_2v0_i;
    endcase
  end

  a_filter_div_min: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (nf_q && !slow_mode_i) |-> (fcpu_div_o >= MIN_FILTER_DIV))
    else $error("Filter on but divider below four.");
  a_slow_div_four: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    slow_mode_i |-> (fcpu_div_o == SLOW_DIV))
    else $error("Slow mode divider not four.");
  // The first edge after reset is skipped, since $stable there still sees the last load made in reset.
  a_options_static: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !$past(sys_rst_i) |-> ($stable(fcpu_q) && $stable(hclk_q) && $stable(wdog_q) &&
    $stable(lv_q) && $stable(rstpin_q) && $stable(sec_q) && $stable(nf_q)))
    else $error("Options changed outside reset.");
  a_wdog_always: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (wdog_q == WDOG_ALWAYS_ON) |-> watchdog_run_o)
    else $error("Always-on watchdog stopped.");
  a_wdog_sleep: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    ((wdog_q == WDOG_ENABLE) && sleep_mode_i) |-> !watchdog_run_o)
    else $error("Watchdog ran in sleep.");
  a_wdog_awake: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    ((wdog_q == WDOG_ENABLE) && !sleep_mode_i) |-> watchdog_run_o)
    else $error("Enabled watchdog stopped while awake.");
  a_wdog_off: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    ((wdog_q != WDOG_ALWAYS_ON) && (wdog_q != WDOG_ENABLE)) |-> !watchdog_run_o)
    else $error("Disabled watchdog running.");
  a_int_rc_pins: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    internal_rc_fast_osc_o |-> (osc_input_pin_is_port_o && !crystal_drive_o))
    else $error("Internal RC pin use wrong.");
  a_ext_rc_pins: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (hclk_q == HCLK_EXT_RC) |-> (osc_output_pin_is_port_o && !osc_input_pin_is_port_o))
    else $error("External RC pin use wrong.");
  a_xtal_pins: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    crystal_drive_o |-> (!osc_input_pin_is_port_o && !osc_output_pin_is_port_o))
    else $error("Crystal pins released to port.");
  a_reset_pin: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (ext_reset_en_o != port1_bit5_input_o) && !port1_bit5_pullup_allow_o)
    else $error("Reset pin selection wrong.");
  a_high_brownout: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (lv_q == LV_HIGH) |-> (brownout_reset_o == supply_below_2v4_i))
    else $error("High level brownout threshold wrong.");
  a_high_flag: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (lv_q == LV_HIGH) |->
    (program_flag_register_o[SUPPLY_LOW_FLAG_HIGH_BIT] == supply_below_3v6_i))
    else $error("High indicator flag wrong.");
  a_mid_flag: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (lv_q == LV_MID) |-> ((brownout_reset_o == supply_below_2v0_i) &&
    (program_flag_register_o[SUPPLY_LOW_FLAG_MID_BIT] == supply_below_2v4_i)))
    else $error("Mid level brownout or flag wrong.");
  a_low_no_flag: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (lv_q == LV_LOW) |-> ((brownout_reset_o == supply_below_2v0_i) &&
    (program_flag_register_o == 8'h00)))
    else $error("Low level brownout or flag wrong.");
  a_option_error: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    option_error_o == (nf_q && ((fcpu_q == FCPU_DIV1) || (fcpu_q == FCPU_DIV2))))
    else $error("Option error flag wrong.");
  a_divider_mode: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (!nf_q && !slow_mode_i && (fcpu_q == FCPU_DIV1)) |-> (fcpu_div_o == 5'h01))
    else $error("Unfiltered divide-by-one not honoured.");
  a_protect: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    rom_protect_o == sec_q)
    else $error("Protection not following option.");
endmodule : cocfg_decoder
`default_nettype wire

// *** dv/cocfg_decoder_tb_top.sv ***
// Self-checking testbench for the code option decoder.
`timescale 1ns/1ps
`default_nettype none
module cocfg_decoder_tb_top;
  import cocfg_pkg::*;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [1:0] hc = 2'h0, wd = 2'h0, lv = 2'h0;
  logic [2:0] fc = 3'h0;
  logic [2:0] cmp = 3'h0;
  logic rp = 1'b0, sec = 1'b0, nf = 1'b0, slow = 1'b0, slp = 1'b0;
  logic irc, ip, op, xd, xf, oe, wr, er, p1b5, pu, rpo, bo;
  logic [4:0] div;
  logic [7:0] pf;
  logic [10:0] cla;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  cocfg_decoder cocfg_decoder_i (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .opt_high_clk_i(hc),
    .opt_watchdog_i(wd), .opt_fcpu_i(fc), .opt_reset_pin_i(rp), .opt_security_i(sec),
    .opt_noise_filter_i(nf), .opt_low_volt_i(lv), .slow_mode_i(slow), .sleep_mode_i(slp),
    .supply_below_2v0_i(cmp[0]), .supply_below_2v4_i(cmp[1]), .supply_below_3v6_i(cmp[2]),
    .internal_rc_fast_osc_o(irc), .osc_input_pin_is_port_o(ip),
    .osc_output_pin_is_port_o(op), .crystal_drive_o(xd), .crystal_fast_o(xf),
    .fcpu_div_o(div), .option_error_o(oe), .watchdog_run_o(wr), .ext_reset_en_o(er),
    .port1_bit5_input_o(p1b5), .port1_bit5_pullup_allow_o(pu), .rom_protect_o(rpo),
    .checksum_last_addr_o(cla), .brownout_reset_o(bo), .program_flag_register_o(pf));
  initial forever #12.5 sys_clk_i = ~sys_clk_i;
  // The full run needs about 320 cycles, so the ceiling only catches a hang.
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic chkv(input logic [10:0] exp, input logic [10:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chkv
  task automatic chk1(input logic exp, input logic got);
    chkv({10'h000, exp}, {10'h000, got});
  endtask : chk1
  task automatic load(input int i);
    @(posedge sys_clk_i);
    sys_rst_i <= 1'b1;
    hc <= 2'(i % 4);
    wd <= 2'(i % 4);
    fc <= 3'(i % 8);
    lv <= 2'(i % 4);
    nf <= (i >= 5);
    rp <= i[0];
    sec <= i[1];
    repeat (2) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
  endtask : load
  task automatic check_all(input int i);
    logic [1:0] h, w, l;
    logic [2:0] f;
    logic n;
    logic [4:0] d;
    h = 2'(i % 4);
    w = 2'(i % 4);
    l = 2'(i % 4);
    f = 3'(i % 8);
    n = (i >= 5);
    d = (n && f < 3'h2) ? MIN_FILTER_DIV : (f >= FCPU_DIV16) ? 5'h10 : 5'h01 << f;
    chk1(h == HCLK_INT_RC, irc);
    chk1(h == HCLK_INT_RC, ip);
    chk1(h == HCLK_INT_RC || h == HCLK_EXT_RC, op);
    chk1(h == HCLK_XTAL_FAST || h == HCLK_XTAL_STD, xd);
    chk1(h == HCLK_XTAL_FAST, xf);
    chk1(i[0], er);
    chk1(!i[0], p1b5);
    chk1(1'b0, pu);
    chk1(i[1], rpo);
    chkv(ROM_LAST_ADDR - 11'h001, cla);
    for (int s = 0; s < 4; s++) begin
      @(posedge sys_clk_i);
      slow <= s[0];
      slp <= s[1];
      #1;
      chkv({6'h00, s[0] ? SLOW_DIV : d}, {6'h00, div});
      chk1(n && f < 3'h2, oe);
      chk1(w == WDOG_ALWAYS_ON || (w == WDOG_ENABLE && !s[1]), wr);
    end
    for (int j = 0; j < 8; j++) begin
      @(posedge sys_clk_i);
      cmp <= 3'(j);
      #1;
      chk1(l == LV_HIGH ? j[1] : j[0], bo);
      chkv({5'h00, l == LV_HIGH && j[2], l == LV_MID && j[1], 4'h0}, {3'h0, pf});
    end
  endtask : check_all
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (8) @(posedge sys_clk_i);
    for (int i = 0; i < 10; i++) begin
      load(i);
      check_all(i);
      // Options moving outside reset must leave every decoded output alone.
      @(posedge sys_clk_i);
      hc <= ~hc;
      wd <= ~wd;
      fc <= ~fc;
      lv <= ~lv;
      nf <= ~nf;
      rp <= ~rp;
      sec <= ~sec;
      repeat (2) @(posedge sys_clk_i);
      #1;
      check_all(i);
      $display("Option set %0d finished", i);
    end
    complete_run();
  end
endmodule : cocfg_decoder_tb_top
`default_nettype wire
